// ---- logic/adc_cmp_pkg.sv ----
// constants, register map and carrier types of the converter control block
// assumes a 200 MHz system clock and a 32-bit apb master with byte addressing
package adc_cmp_pkg;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_STATUS_CONTROL_ONE = 14'h0000;
  localparam logic [13:0] IDX_STATUS_CONTROL_TWO = 14'h0001;
  localparam logic [13:0] IDX_RESULT_HIGH        = 14'h0004;
  localparam logic [13:0] IDX_RESULT_LOW         = 14'h0005;
  localparam logic [13:0] IDX_COMPARE_HIGH       = 14'h0006;
  localparam logic [13:0] IDX_COMPARE_LOW        = 14'h0007;
  localparam logic [13:0] IDX_IRQ_STATUS         = 14'h0008;
  localparam logic [13:0] IDX_IRQ_MASK           = 14'h0009;
  localparam logic [13:0] IDX_PIN_SELECT_LOW     = 14'h309C;
  localparam logic [13:0] IDX_PIN_SELECT_HIGH    = 14'h309D;

  // field positions
  localparam int STC1_DONE_BIT   = 7;
  localparam int STC1_IE_BIT     = 6;
  localparam int STC2_CMP_EN_BIT = 0;
  localparam int STC2_MODE8_BIT  = 1;
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_ABORT_BIT   = 1;

  // reset values
  localparam logic [4:0]  CHANNEL_RESET  = 5'h1F;
  localparam logic [4:0]  CHANNEL_OFF    = 5'h1F;
  localparam logic [7:0]  PIN_LOW_RESET  = 8'h00;
  localparam logic [3:0]  PIN_HIGH_RESET = 4'h0;
  localparam logic [9:0]  COMPARE_RESET  = 10'h000;
  localparam logic [9:0]  RESULT_RESET   = 10'h000;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;

  // converter clock derived from the system clock
  localparam int SYS_CLOCK_HZ   = 200_000_000;
  localparam int CONV_CLOCK_HZ  = 10_000_000;
  localparam int CONV_DIV_COUNT = SYS_CLOCK_HZ / CONV_CLOCK_HZ;
  localparam logic [7:0] CONV_DIV_LAST = 8'(CONV_DIV_COUNT - 1);

  // sampling lasts 3.5 converter cycles, rounded up
  localparam int SAMPLE_HALF_CYCLES = 7;
  localparam logic [3:0] SAMPLE_TICKS = 4'((SAMPLE_HALF_CYCLES + 1) / 2);

  // internal approximation width, two guard bits below the 10-bit result
  localparam int SAR_WIDTH = 12;

  typedef enum logic [2:0] {
    SAR_IDLE    = 3'b001,
    SAR_SAMPLE  = 3'b010,
    SAR_CONVERT = 3'b100
  } sar_state_type;

  // forced conditions on the analog-capable pins
  typedef struct packed {
    logic [11:0] output_tristate;
    logic [11:0] input_disable;
    logic [11:0] pullup_disable;
  } pin_ctrl_type;

endpackage : adc_cmp_pkg

// ---- logic/sar_engine.sv ----
// successive approximation sequencer: sample phase then one trial per bit
// assumes an external comparator that reports input >= trial code each tick
module sar_engine (
  input  wire logic                              sys_clk,
  input  wire logic                              rst_n,
  input  wire logic                              tick,
  input  wire logic                              start,
  input  wire logic                              abort,
  input  wire logic                              comparator_above,
  output logic [adc_cmp_pkg::SAR_WIDTH-1:0]      trial_code,
  output logic                                   busy,
  output logic                                   done
);

  adc_cmp_pkg::sar_state_type state;
  logic [3:0] count;

  // start wins over abort so a channel write restarts the sequence
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= adc_cmp_pkg::SAR_IDLE;
      count      <= 4'h0;
      trial_code <= 12'h000;
      done       <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        state <= adc_cmp_pkg::SAR_SAMPLE;
        count <= 4'h0;
      end else if (abort) begin
        state <= adc_cmp_pkg::SAR_IDLE;
      end else if (tick) begin
        case (state)
          adc_cmp_pkg::SAR_SAMPLE: begin
            count <= count + 4'h1;
            if (count == adc_cmp_pkg::SAMPLE_TICKS - 4'h1) begin
              state      <= adc_cmp_pkg::SAR_CONVERT;
              count      <= 4'(adc_cmp_pkg::SAR_WIDTH - 1);
              trial_code <= 12'h800;
            end
          end
          adc_cmp_pkg::SAR_CONVERT: begin
            // keep the trial bit only if the input is at or above it
            if (!comparator_above) begin
              trial_code[count] <= 1'b0;
            end
            if (count == 4'h0) begin
              state <= adc_cmp_pkg::SAR_IDLE;
              done  <= 1'b1;
            end else begin
              trial_code[count - 4'h1] <= 1'b1;
              count <= count - 4'h1;
            end
          end
          adc_cmp_pkg::SAR_IDLE: begin
            count <= 4'h0;
          end
          default: begin
            state <= adc_cmp_pkg::SAR_IDLE;
          end
        endcase
      end
    end
  end

  assign busy = (state != adc_cmp_pkg::SAR_IDLE);

endmodule : sar_engine

// ---- logic/adc_compare_and_pin_control.sv ----
// converter control: apb registers, compare value, pin control, result placement
// assumes a zero-latency external comparator and port logic that obeys pin_ctrl
//
// Summary of operation
// - in 10-bit mode compare-high bits 1:0 match result bits 9:8
// - compare-high bits 7:2 are read-only and read as zero
// - compare-low holds compare bits 7:0 matched to result low byte
// - pin-select-low bit n set removes port control of channel n pin
// - pin-select-high bits 3:0 serve channels 11:8, bits 7:4 reserved zero
// - converter disabled in reset and while channel select is all ones
// - after a conversion with none started the converter idles powered down
// - selected channel converted by successive approximation, 10 or 8 bits
// - 10-bit mode rounds to ten bits across result high and low
// - 8-bit mode rounds to eight bits written only to result low
// - done flag set in the same cycle as placement; interrupt when done enable is one
// - compare enable activates automatic compare in every mode
// - compare enabled and condition false leaves result registers unchanged
// - writing either compare register aborts the conversion in progress
// - disabled pin: output high impedance, input reads zero, pullup off
module adc_compare_and_pin_control (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic [15:0]                   paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          comparator_above,
  input  wire logic [11:0]                   port_pin_in,
  output logic [adc_cmp_pkg::SAR_WIDTH-1:0]  dac_trial_code,
  output logic [4:0]                         selected_channel,
  output logic                               converter_active,
  output adc_cmp_pkg::pin_ctrl_type          pin_ctrl,
  output logic [11:0]                        port_read_data,
  output logic                               irq
);

  logic [7:0]  div_count;
  logic        tick;
  logic [13:0] word;
  logic        access;
  logic        commit;
  logic        wr;
  logic        rd;
  logic        hit;
  logic [7:0]  read_value;
  logic [1:0]  compare_high;
  logic [7:0]  compare_low;
  logic [7:0]  pin_select_low;
  logic [3:0]  pin_select_high;
  logic [4:0]  channel_select;
  logic        done_interrupt_enable;
  logic        compare_enable;
  logic        eight_bit_mode;
  logic        conversion_done_flag;
  logic [1:0]  result_high;
  logic [7:0]  result_low;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic        start;
  logic        abort;
  logic        sar_busy;
  logic        sar_done;
  logic [9:0]  rounded10;
  logic [7:0]  rounded8;
  logic [9:0]  result_value;
  logic [9:0]  compare_value;
  logic        compare_met;
  logic        accept;
  logic [11:0] pin_disable;

  // converter clock enable; one cycle pulse per converter period
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= 8'h00;
      tick      <= 1'b0;
    end else begin
      tick <= (div_count == adc_cmp_pkg::CONV_DIV_LAST);
      if (div_count == adc_cmp_pkg::CONV_DIV_LAST) begin
        div_count <= 8'h00;
      end else begin
        div_count <= div_count + 8'h01;
      end
    end
  end

  // apb phases: one wait state so read data comes from a flop
  assign word   = paddr[15:2];
  assign access = psel & penable & ~pready;
  assign commit = psel & penable & pready;
  assign wr     = commit & pwrite;
  assign rd     = commit & ~pwrite;

  // address decode and read mux; reserved bits read as zero
  always_comb begin
    hit        = 1'b1;
    read_value = 8'h00;
    case (word)
      adc_cmp_pkg::IDX_STATUS_CONTROL_ONE: begin
        read_value[adc_cmp_pkg::STC1_DONE_BIT] = conversion_done_flag;
        read_value[adc_cmp_pkg::STC1_IE_BIT]   = done_interrupt_enable;
        read_value[4:0]                        = channel_select;
      end
      adc_cmp_pkg::IDX_STATUS_CONTROL_TWO: begin
        read_value[adc_cmp_pkg::STC2_CMP_EN_BIT] = compare_enable;
        read_value[adc_cmp_pkg::STC2_MODE8_BIT]  = eight_bit_mode;
      end
      adc_cmp_pkg::IDX_RESULT_HIGH:     read_value = {6'h00, result_high};
      adc_cmp_pkg::IDX_RESULT_LOW:      read_value = result_low;
      adc_cmp_pkg::IDX_COMPARE_HIGH:    read_value = {6'h00, compare_high};
      adc_cmp_pkg::IDX_COMPARE_LOW:     read_value = compare_low;
      adc_cmp_pkg::IDX_IRQ_STATUS:      read_value = {6'h00, irq_status};
      adc_cmp_pkg::IDX_IRQ_MASK:        read_value = {6'h00, irq_mask};
      adc_cmp_pkg::IDX_PIN_SELECT_LOW:  read_value = pin_select_low;
      adc_cmp_pkg::IDX_PIN_SELECT_HIGH: read_value = {4'h0, pin_select_high};
      default:                          hit = 1'b0;
    endcase
  end

  // bus answer: ready one cycle after the access phase opens
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access & ~hit;
      if (access & ~pwrite) begin
        prdata <= {24'h00_0000, read_value};
      end
    end
  end

  // compare value; any write invalidates the running conversion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_high <= adc_cmp_pkg::COMPARE_RESET[9:8];
      compare_low  <= adc_cmp_pkg::COMPARE_RESET[7:0];
    end else if (wr) begin
      if (word == adc_cmp_pkg::IDX_COMPARE_HIGH) begin
        compare_high <= pwdata[1:0];
      end
      if (word == adc_cmp_pkg::IDX_COMPARE_LOW) begin
        compare_low <= pwdata[7:0];
      end
    end
  end

  // pin control registers; upper nibble of the high register is not stored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_select_low  <= adc_cmp_pkg::PIN_LOW_RESET;
      pin_select_high <= adc_cmp_pkg::PIN_HIGH_RESET;
    end else if (wr) begin
      if (word == adc_cmp_pkg::IDX_PIN_SELECT_LOW) begin
        pin_select_low <= pwdata[7:0];
      end
      if (word == adc_cmp_pkg::IDX_PIN_SELECT_HIGH) begin
        pin_select_high <= pwdata[3:0];
      end
    end
  end

  // control fields; channel all ones at reset keeps the converter off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_select        <= adc_cmp_pkg::CHANNEL_RESET;
      done_interrupt_enable <= 1'b0;
      compare_enable        <= 1'b0;
      eight_bit_mode        <= 1'b0;
    end else if (wr) begin
      if (word == adc_cmp_pkg::IDX_STATUS_CONTROL_ONE) begin
        channel_select        <= pwdata[4:0];
        done_interrupt_enable <= pwdata[adc_cmp_pkg::STC1_IE_BIT];
      end
      if (word == adc_cmp_pkg::IDX_STATUS_CONTROL_TWO) begin
        compare_enable <= pwdata[adc_cmp_pkg::STC2_CMP_EN_BIT];
        eight_bit_mode <= pwdata[adc_cmp_pkg::STC2_MODE8_BIT];
      end
    end
  end

  // channel write starts unless all ones; mode and compare writes abort
  assign start = wr & (word == adc_cmp_pkg::IDX_STATUS_CONTROL_ONE)
               & (pwdata[4:0] != adc_cmp_pkg::CHANNEL_OFF);
  assign abort = wr & ((word == adc_cmp_pkg::IDX_STATUS_CONTROL_ONE)
               | (word == adc_cmp_pkg::IDX_STATUS_CONTROL_TWO)
               | (word == adc_cmp_pkg::IDX_COMPARE_HIGH)
               | (word == adc_cmp_pkg::IDX_COMPARE_LOW));

  // the sequencer sits idle, and the analog side unpowered, when not busy
  sar_engine u_sar (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .tick             (tick),
    .start            (start),
    .abort            (abort),
    .comparator_above (comparator_above),
    .trial_code       (dac_trial_code),
    .busy             (sar_busy),
    .done             (sar_done)
  );

  assign converter_active = sar_busy;
  assign selected_channel = channel_select;

  // round half up from the guard bits, saturating at full scale
  always_comb begin
    if (dac_trial_code[11:2] == 10'h3FF) begin
      rounded10 = 10'h3FF;
    end else begin
      rounded10 = dac_trial_code[11:2] + {9'h000, dac_trial_code[1]};
    end
    if (dac_trial_code[11:4] == 8'hFF) begin
      rounded8 = 8'hFF;
    end else begin
      rounded8 = dac_trial_code[11:4] + {7'h00, dac_trial_code[3]};
    end
  end

  // compare condition: result at or above the compare value
  assign result_value  = eight_bit_mode ? {2'b00, rounded8} : rounded10;
  assign compare_value = eight_bit_mode ? {2'b00, compare_low}
                                        : {compare_high, compare_low};
  assign compare_met   = (result_value >= compare_value);
  assign accept        = sar_done & (~compare_enable | compare_met);

  // result placement; a failed compare simply drops the result
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_high <= adc_cmp_pkg::RESULT_RESET[9:8];
      result_low  <= adc_cmp_pkg::RESULT_RESET[7:0];
    end else if (accept) begin
      if (eight_bit_mode) begin
        result_low <= rounded8;
      end else begin
        result_high <= rounded10[9:8];
        result_low  <= rounded10[7:0];
      end
    end
  end

  // done flag cleared by a result-low read or channel write; set wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_done_flag <= 1'b0;
    end else if (accept) begin
      conversion_done_flag <= 1'b1;
    end else if ((rd & (word == adc_cmp_pkg::IDX_RESULT_LOW))
               | (wr & (word == adc_cmp_pkg::IDX_STATUS_CONTROL_ONE))) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // sticky events, write one to clear, a new event beats the clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= adc_cmp_pkg::IRQ_RESET;
      irq_mask   <= adc_cmp_pkg::IRQ_RESET;
    end else begin
      if (wr & (word == adc_cmp_pkg::IDX_IRQ_MASK)) begin
        irq_mask <= pwdata[1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if ((i == adc_cmp_pkg::IRQ_DONE_BIT) & accept) begin
          irq_status[i] <= 1'b1;
        end else if ((i == adc_cmp_pkg::IRQ_ABORT_BIT) & abort & sar_busy) begin
          irq_status[i] <= 1'b1;
        end else if (wr & (word == adc_cmp_pkg::IDX_IRQ_STATUS) & pwdata[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  // level interrupt from the done flag when done enable is one, or any unmasked sticky event
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (conversion_done_flag & done_interrupt_enable)
           | (|(irq_status & irq_mask));
    end
  end

  // one disable bit drives all three forced pin conditions
  assign pin_disable              = {pin_select_high, pin_select_low};
  assign pin_ctrl.output_tristate = pin_disable;
  assign pin_ctrl.input_disable   = pin_disable;
  assign pin_ctrl.pullup_disable  = pin_disable;

  // port reads of a disabled pin return zero; registered to keep outputs clean
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_read_data <= 12'h000;
    end else begin
      port_read_data <= port_pin_in & ~pin_disable;
    end
  end

endmodule : adc_compare_and_pin_control

// ---- tb/adc_cmp_monitor.sv ----
// port checker for the converter control block
// assumes an apb master that holds each request until pready is sampled high
module adc_cmp_monitor (
  input wire logic                      sys_clk,
  input wire logic                      rst_n,
  input wire logic [15:0]               paddr,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic [11:0]               port_pin_in,
  input wire logic [4:0]                selected_channel,
  input wire logic                      converter_active,
  input wire adc_cmp_pkg::pin_ctrl_type pin_ctrl,
  input wire logic [11:0]               port_read_data,
  input wire logic                      irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] idx;
  logic        wr_done;
  logic        rd_done;
  logic [11:0] masked_in;
  // completed transfers, seen at the pready edge
  assign idx       = paddr[15:2];
  assign wr_done   = psel && penable && pready && pwrite;
  assign rd_done   = psel && penable && pready && !pwrite;
  assign masked_in = port_pin_in & ~pin_ctrl.input_disable;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_pin_mirror: assert property (pin_ctrl.output_tristate == pin_ctrl.input_disable
    && pin_ctrl.pullup_disable == pin_ctrl.input_disable) else $error("pin fields differ");
  // flop lags one cycle
  a_port_read_mask: assert property ($past(rst_n) |-> port_read_data == $past(masked_in))
    else $error("port read not masked");
  a_pin_low_write: assert property (wr_done && idx == adc_cmp_pkg::IDX_PIN_SELECT_LOW
    |=> pin_ctrl.input_disable[7:0] == $past(pwdata[7:0])) else $error("pin low not applied");
  a_pin_high_write: assert property (wr_done && idx == adc_cmp_pkg::IDX_PIN_SELECT_HIGH
    |=> pin_ctrl.input_disable[11:8] == $past(pwdata[3:0])) else $error("pin high not applied");
  a_compare_high_reserved: assert property (rd_done
    && idx == adc_cmp_pkg::IDX_COMPARE_HIGH |-> prdata[31:2] == 30'h0)
    else $error("compare high reserved bits set");
  a_pin_high_reserved: assert property (rd_done
    && idx == adc_cmp_pkg::IDX_PIN_SELECT_HIGH |-> prdata[31:4] == 28'h0)
    else $error("pin high reserved bits set");
  a_off_all_ones: assert property (selected_channel == 5'h1F
    && $past(selected_channel) == 5'h1F |-> !converter_active) else $error("active while off");
  a_start_after_write: assert property ($rose(converter_active)
    |-> $past(wr_done) || $past(wr_done, 2)) else $error("woke without a start");
  a_compare_write_abort: assert property (wr_done && (idx == adc_cmp_pkg::IDX_COMPARE_HIGH
    || idx == adc_cmp_pkg::IDX_COMPARE_LOW) |-> ##2 !converter_active [*3])
    else $error("compare write did not abort");
  c_conv_end: cover property ($fell(converter_active));
  c_irq_up: cover property ($rose(irq));
  c_refused: cover property (rd_done && pslverr);
endmodule : adc_cmp_monitor

bind adc_compare_and_pin_control adc_cmp_monitor i_mon (.sys_clk, .rst_n, .paddr, .psel,
  .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .port_pin_in, .selected_channel,
  .converter_active, .pin_ctrl, .port_read_data, .irq);

// ---- tb/pin_port_model.sv ----
// port pins and analog comparator outside the converter control block
// assumes an ideal comparator and pins left floating once port control is removed
module pin_port_model (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic [11:0][11:0]          analog_level,
  input  wire logic [11:0]                drive_level,
  input  wire logic [4:0]                 selected_channel,
  input  wire logic [11:0]                dac_trial_code,
  input  wire adc_cmp_pkg::pin_ctrl_type  pin_ctrl,
  output logic                            comparator_above,
  output logic [11:0]                     port_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] float_pat;
  // a floating pin toggles, never holds a stale level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) float_pat <= 12'hA5A;
    else float_pat <= ~float_pat;
  end
  // zero-latency comparator; channels above 11 have no input and read low
  assign comparator_above = (selected_channel < 5'h0C)
    && (analog_level[selected_channel[3:0]] >= dac_trial_code);
  // released pins lose their pullup and float
  assign port_pin_in = (drive_level & ~pin_ctrl.output_tristate)
    | (float_pat & pin_ctrl.pullup_disable);
endmodule : pin_port_model

// ---- tb/adc_compare_and_pin_control_tb_top.sv ----
// self-checking bench for the converter control block, registers over apb
// assumes the pin model beside the block and the checker bound into it
module adc_compare_and_pin_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [15:0]       paddr = 16'h0000;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = 32'h0, prdata, seed = 32'hE7D3E729;
  logic              pready, pslverr, comparator_above, converter_active, irq;
  logic [11:0]       port_pin_in, dac_trial_code, port_read_data, drive_level = 12'h000;
  logic [11:0][11:0] analog_level = '0;
  logic [4:0]        selected_channel;
  adc_cmp_pkg::pin_ctrl_type pin_ctrl;
  logic [32:0]       exp_q[$];
  logic [32:0]       note;
  int                fail_count = 0, samples_checked = 0, cycles = 0;
  // index aliases
  localparam logic [13:0] CTL1 = adc_cmp_pkg::IDX_STATUS_CONTROL_ONE,
    CTL2 = adc_cmp_pkg::IDX_STATUS_CONTROL_TWO, RES_H = adc_cmp_pkg::IDX_RESULT_HIGH,
    RES_L = adc_cmp_pkg::IDX_RESULT_LOW, CMP_H = adc_cmp_pkg::IDX_COMPARE_HIGH,
    CMP_L = adc_cmp_pkg::IDX_COMPARE_LOW, IRQ_ST = adc_cmp_pkg::IDX_IRQ_STATUS,
    PIN_L = adc_cmp_pkg::IDX_PIN_SELECT_LOW, PIN_H = adc_cmp_pkg::IDX_PIN_SELECT_HIGH;

  adc_compare_and_pin_control i_dut (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .comparator_above, .port_pin_in, .dac_trial_code,
    .selected_channel, .converter_active, .pin_ctrl, .port_read_data, .irq);
  pin_port_model i_pins (.sys_clk, .rst_n, .analog_level, .drive_level, .selected_channel,
    .dac_trial_code, .pin_ctrl, .comparator_above, .port_pin_in);

  always #2.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand
  // round half up from the guard bits, clipped at full scale
  function automatic logic [9:0] round10(input logic [11:0] raw);
    logic [12:0] s;
    s = {1'b0, raw} + 13'h0002;
    return s[12] ? 10'h3FF : s[11:2];
  endfunction : round10
  function automatic logic [7:0] round8(input logic [11:0] raw);
    logic [12:0] s;
    s = {1'b0, raw} + 13'h0008;
    return s[12] ? 8'hFF : s[11:4];
  endfunction : round8

  task automatic print_verdict();
    if (fail_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // one apb transfer; only the global timer ends a slave that never answers
  task automatic xfer(input logic [13:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge sys_clk);
    paddr  <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= wd;
    psel   <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, {24'h000000, d});
  endtask : wr
  // the expectation is noted before the read goes out
  task automatic rd(input logic [13:0] idx, input logic [7:0] d, input logic err = 1'b0);
    exp_q.push_back({err, 24'h000000, d});
    xfer(idx, 1'b0, 32'h00000000);
  endtask : rd
  // start a conversion, wait until it is placed
  task automatic conv(input logic [4:0] ch, input logic ie);
    wr(CTL1, {1'b0, ie, 1'b0, ch});
    repeat (2) @(posedge sys_clk);
    while (converter_active !== 1'b0) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask : conv

  // match each read answer to the oldest note
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) note = 33'h1FFFFFFFF;
      else note = exp_q.pop_front();
      `CHK("prdata", note[31:0], prdata)
      `CHK("pslverr", note[32], pslverr)
    end
  end
  // hang guard, far above the run's length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    logic [7:0] a, b;
    logic [9:0] r;
    logic [4:0] ch;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values, then a refused unmapped place
    rd(CTL1, 8'h1F);
    rd(CMP_H, 8'h00);
    rd(CMP_L, 8'h00);
    rd(PIN_L, 8'h00);
    rd(PIN_H, 8'h00);
    wr(14'h0100, 8'h5A);
    rd(14'h0100, 8'h00, 1'b1);
    `CHK("active", 1'b0, converter_active)
    a = 8'(next_rand());
    b = 8'(next_rand());
    wr(CMP_H, a | 8'hFC);
    rd(CMP_H, {6'h00, a[1:0]});
    wr(CMP_L, b);
    rd(CMP_L, b);
    // random pin masks; released pins float yet must read zero
    repeat (3) begin
      a = 8'(next_rand());
      b = 8'(next_rand());
      drive_level <= 12'(next_rand());
      wr(PIN_L, a);
      wr(PIN_H, b);
      rd(PIN_L, a);
      rd(PIN_H, {4'h0, b[3:0]});
      `CHK("pin_ctrl", {3{b[3:0], a}}, pin_ctrl)
      `CHK("port_read", drive_level & ~{b[3:0], a}, port_read_data)
    end
    // channel 3 sits at full scale to hit the rounding clip
    for (int i = 0; i < 12; i++) analog_level[i] <= (i == 3) ? 12'hFFF : 12'(next_rand());
    for (int k = 0; k < 2; k++) begin
      ch = k ? 5'(next_rand() % 11) : 5'h03;
      wr(adc_cmp_pkg::IDX_IRQ_MASK, 8'h00);
      conv(ch, 1'b1);
      r = round10(analog_level[ch[3:0]]);
      `CHK("irq_done", 1'b1, irq)
      rd(RES_H, {6'h00, r[9:8]});
      rd(CTL1, {3'b110, ch});
      rd(RES_L, r[7:0]);
      repeat (3) @(posedge sys_clk);
      `CHK("irq_masked", 1'b0, irq)
      rd(IRQ_ST, 8'h01);
      wr(adc_cmp_pkg::IDX_IRQ_MASK, 8'h01);
      repeat (3) @(posedge sys_clk);
      `CHK("irq_unmasked", 1'b1, irq)
      wr(IRQ_ST, 8'h01);
      repeat (3) @(posedge sys_clk);
      `CHK("irq_cleared", 1'b0, irq)
      `CHK("idle", 1'b0, converter_active)
    end
    // eight-bit mode leaves the high result alone
    wr(CTL2, 8'h02);
    conv(5'h07, 1'b0);
    rd(RES_H, {6'h00, r[9:8]});
    rd(RES_L, round8(analog_level[7]));
    // compare one above the result refuses it, equal accepts it
    analog_level[5] <= 12'h400;
    wr(CTL2, 8'h01);
    wr(CMP_H, 8'h01);
    wr(CMP_L, 8'h01);
    conv(5'h05, 1'b0);
    rd(RES_L, round8(analog_level[7]));
    rd(CTL1, 8'h05);
    wr(CMP_L, 8'h00);
    conv(5'h05, 1'b0);
    rd(RES_H, 8'h01);
    rd(CTL1, 8'h85);
    rd(RES_L, 8'h00);
    // same pair with eight-bit results
    wr(CTL2, 8'h03);
    wr(CMP_L, 8'h41);
    conv(5'h05, 1'b0);
    rd(RES_L, 8'h00);
    wr(CMP_L, 8'h40);
    conv(5'h05, 1'b0);
    rd(RES_L, 8'h40);
    // a compare write mid-conversion abandons it, results kept
    wr(CTL2, 8'h00);
    wr(CTL1, 8'h07);
    repeat (100) @(posedge sys_clk);
    `CHK("busy", 1'b1, converter_active)
    wr(CMP_L, 8'h00);
    repeat (3) @(posedge sys_clk);
    `CHK("aborted", 1'b0, converter_active)
    rd(RES_L, 8'h40);
    rd(IRQ_ST, 8'h03);
    // all ones stops a running conversion
    wr(CTL1, 8'h02);
    repeat (50) @(posedge sys_clk);
    wr(CTL1, 8'h1F);
    repeat (40) @(posedge sys_clk);
    `CHK("off", 1'b0, converter_active)
    print_verdict();
  end
endmodule : adc_compare_and_pin_control_tb_top
